//--- inc/ht_pkg.sv
package ht_pkg;
  // bus address and command bytes
  localparam logic [6:0] HT_ADDR = 7'h44;
  localparam logic [7:0] CMD_PROG_ENTER = 8'ha0;
  localparam logic [7:0] CMD_PROG_EXIT = 8'h80;
  localparam logic [7:0] REG_HRES_RD = 8'h06;
  localparam logic [7:0] REG_TRES_RD = 8'h11;
  localparam logic [7:0] REG_ID_HI = 8'h1e;
  localparam logic [7:0] REG_ID_LO = 8'h1f;
  localparam logic [7:0] REG_HRES_WR = 8'h46;
  localparam logic [7:0] REG_TRES_WR = 8'h51;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] CMD_BYTES = 3'h3;
  // resolution field in the 16-bit resolution registers
  localparam int RES_MSB = 11;
  localparam int RES_LSB = 10;
  localparam logic [1:0] RES_DEFAULT = 2'h3;
  localparam logic [15:0] RES_REG_RESET = 16'h0c00;
  // status codes in the first fetched byte
  localparam logic [1:0] STAT_VALID = 2'h0;
  localparam logic [1:0] STAT_STALE = 2'h1;
  // timing, clock at 20 MHz
  localparam int CLK_NS = 50;
  localparam int CLK_MHZ = 1000 / CLK_NS;
  localparam int NV_LOAD_US = 120;
  localparam int NV_LOAD_CYC = NV_LOAD_US * CLK_MHZ;
  localparam int NV_STORE_MS = 14;
  localparam int PROG_WIN_MS = 10;
  localparam int MEAS_8_US = 1200;
  localparam int MEAS_10_US = 2720;
  localparam int MEAS_12_US = 9100;
  localparam int MEAS_14_US = 33900;
  localparam int TMR_W = 20;
  localparam int SCL_QTR_NS = 2500;
  localparam int SCL_QTR_CYC = SCL_QTR_NS / CLK_NS;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX = 3'b001,
    D_RX_ACK = 3'b010,
    D_TX = 3'b011,
    D_TX_ACK = 3'b100
  } ht_dst_type;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } ht_hst_type;
endpackage

//--- inc/ht_link_if.sv
`timescale 1ns/100ps
interface ht_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // open-drain wires with pull-ups: low whenever any party drives
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
  modport dev (output dev_sda_oe, input scl, input sda);
endinterface

//--- design/ht_dev.sv
`timescale 1ns/100ps
// How it works
// (RULE_01) addressed write wakes sensor, starts measurement
// (RULE_02) convert, correct, update output, then sleep
// (RULE_03) results fourteen bits, sent msb first
// (RULE_04) addressed read is acked, result bytes follow
// (RULE_05) bytes continue until controller nacks, stops
// (RULE_06) bytes one-two: status then humidity
// (RULE_07) bytes three-four: temperature left aligned
// (RULE_08) controller may stop after byte two/three
// (RULE_09) measurement time follows resolution table
// (RULE_10) status valid until fetched, then stale
// (RULE_11) fetch before first result reads stale
// (RULE_12) a0 00 00 within 10 ms enters programming
// (RULE_13) entry takes 120 us; registers sixteen bits
// (RULE_14) 80 00 00 leaves programming mode
// (RULE_15) resolution read and write at separate addresses
// (RULE_16) id upper at 1e, lower at 1f
// (RULE_17) bits 11:10 code 8/10/12/14 bits
// (RULE_18) resolutions independent, default fourteen bits
// (RULE_19) controller rewrites whole register, changing 11:10
// (RULE_20) load 120 us, store 14 ms
// (RULE_21) answers only address 44 hex
// (RULE_22) core converts only on measurement request
// (RULE_23) register read: write address, 00 00, read
// (RULE_24) register write: address then value msb first
module ht_dev #(
  parameter int MEAS_8_CYC = ht_pkg::MEAS_8_US * ht_pkg::CLK_MHZ,
  parameter int MEAS_10_CYC = ht_pkg::MEAS_10_US * ht_pkg::CLK_MHZ,
  parameter int MEAS_12_CYC = ht_pkg::MEAS_12_US * ht_pkg::CLK_MHZ,
  parameter int MEAS_14_CYC = ht_pkg::MEAS_14_US * ht_pkg::CLK_MHZ,
  parameter int NV_STORE_CYC = ht_pkg::NV_STORE_MS * 1000 * ht_pkg::CLK_MHZ,
  parameter int PROG_WIN_CYC = ht_pkg::PROG_WIN_MS * 1000 * ht_pkg::CLK_MHZ,
  parameter logic [15:0] ID_HI = 16'h1234, // arbitrary value
  parameter logic [15:0] ID_LO = 16'h5678 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic nrst,
  ht_link_if.dev lnk,
  input wire logic [13:0] hum_in,
  input wire logic [13:0] tmp_in,
  output logic core_awake,
  output logic prog_mode,
  output logic nv_busy
);
  import ht_pkg::*;

  typedef struct packed {
    ht_dst_type st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic is_addr;
    logic rw;
    logic wr_act;
    logic mnack;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [2:0] bidx;
    logic sda_oe;
    logic measuring;
    logic [TMR_W-1:0] mtmr;
    logic prog;
    logic win;
    logic [TMR_W-1:0] wtmr;
    logic nv_busy;
    logic [TMR_W-1:0] nvtmr;
    logic [1:0] stat;
    logic [13:0] hum;
    logic [13:0] tmp;
    logic [15:0] hres;
    logic [15:0] tres;
    logic [15:0] nvrd;
  } ht_dev_st_type;

  localparam ht_dev_st_type RST = '{
    st: D_IDLE, scl_s: 3'h7, sda_s: 3'h7, is_addr: 1'b0, rw: 1'b0, wr_act: 1'b0,
    mnack: 1'b0, bitc: 4'h0, sh: 8'h00, cmd: 8'h00, b1: 8'h00, b2: 8'h00,
    bidx: 3'h0, sda_oe: 1'b0, measuring: 1'b0, mtmr: '0, prog: 1'b0, win: 1'b1,
    wtmr: '0, nv_busy: 1'b0, nvtmr: '0, stat: STAT_STALE, hum: 14'h0000,
    tmp: 14'h0000, hres: RES_REG_RESET, tres: RES_REG_RESET, nvrd: 16'h0000};

  ht_dev_st_type q;
  ht_dev_st_type d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // edges seen on second and third stages; stage one feeds stage two only
  assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
  assign bus_start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
  assign bus_stop = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];

  // per-quantity conversion time in cycles
  function automatic logic [TMR_W:0] meas_cyc(input logic [1:0] code);
    case (code) // [RULE_17]
      2'b00: meas_cyc = (TMR_W+1)'(MEAS_8_CYC);
      2'b01: meas_cyc = (TMR_W+1)'(MEAS_10_CYC);
      2'b10: meas_cyc = (TMR_W+1)'(MEAS_12_CYC);
      default: meas_cyc = (TMR_W+1)'(MEAS_14_CYC);
    endcase
  endfunction

  // mixed resolutions use the mean of both table times
  function automatic logic [TMR_W-1:0] meas_total(input logic [1:0] hc, input logic [1:0] tc);
    logic [TMR_W:0] s;
    s = meas_cyc(hc) + meas_cyc(tc);
    meas_total = s[TMR_W:1]; // [RULE_09]
  endfunction

  // byte to send at a given position of a read
  function automatic logic [7:0] tx_byte(input ht_dev_st_type s, input logic [2:0] i);
    tx_byte = FILL_BYTE;
    if (s.prog) begin
      if (i == 3'h0) begin
        tx_byte = s.nvrd[15:8]; // [RULE_23]
      end else if (i == 3'h1) begin
        tx_byte = s.nvrd[7:0];
      end
    end else begin
      case (i)
        3'h0: tx_byte = {s.stat, s.hum[13:8]}; // [RULE_06]
        3'h1: tx_byte = s.hum[7:0]; // [RULE_03]
        3'h2: tx_byte = s.tmp[13:6]; // [RULE_07]
        3'h3: tx_byte = {s.tmp[5:0], 2'b00}; // undefined low bits [RULE_07]
        default: tx_byte = FILL_BYTE;
      endcase
    end
  endfunction

  // next-state logic for link, timers and registers
  always_comb begin
    logic [7:0] nb;
    nb = 8'h00;
    d = q;
    d.scl_s = {q.scl_s[1:0], lnk.scl};
    d.sda_s = {q.sda_s[1:0], lnk.sda};

    // power-up window for programming entry
    if (q.win) begin
      d.wtmr = q.wtmr + 1'b1;
      if (q.wtmr == TMR_W'(PROG_WIN_CYC - 1)) begin
        d.win = 1'b0; // [RULE_12]
      end
    end

    // non-volatile load/store busy time
    if (q.nv_busy) begin
      d.nvtmr = q.nvtmr - 1'b1;
      if (q.nvtmr == TMR_W'(1)) begin
        d.nv_busy = 1'b0; // [RULE_20]
      end
    end

    // byte engine
    case (q.st)
      D_RX: begin
        if (scl_rise) begin
          d.sh = {q.sh[6:0], q.sda_s[2]};
          d.bitc = q.bitc + 1'b1;
        end else if (scl_fall && q.bitc == 4'h8) begin
          if (q.is_addr) begin
            if (q.sh[7:1] == HT_ADDR) begin // [RULE_21]
              d.sda_oe = 1'b1;
              d.rw = q.sh[0];
              d.st = D_RX_ACK;
              if (!q.sh[0]) begin
                d.wr_act = 1'b1;
                if (!q.prog) begin
                  d.measuring = 1'b1; // [RULE_01] [RULE_22]
                  d.mtmr = meas_total(q.hres[RES_MSB:RES_LSB], q.tres[RES_MSB:RES_LSB]);
                end
              end
            end else begin
              d.st = D_IDLE; // not ours, wait for next start
            end
          end else begin
            if (q.bidx == 3'h0) begin
              d.cmd = q.sh;
            end else if (q.bidx == 3'h1) begin
              d.b1 = q.sh;
            end else if (q.bidx == 3'h2) begin
              d.b2 = q.sh;
            end
            if (q.bidx != 3'h7) begin
              d.bidx = q.bidx + 1'b1;
            end
            d.sda_oe = 1'b1;
            d.st = D_RX_ACK;
          end
        end
      end
      D_RX_ACK: begin
        if (scl_fall) begin
          d.is_addr = 1'b0;
          d.bitc = 4'h0;
          if (q.rw) begin
            nb = tx_byte(q, 3'h0);
            if (!q.prog) begin
              d.stat = STAT_STALE; // this byte still carries the old code [RULE_10] [RULE_11]
            end
            d.sh = nb;
            d.sda_oe = ~nb[7]; // [RULE_04]
            d.st = D_TX;
          end else begin
            d.sda_oe = 1'b0;
            d.st = D_RX;
          end
        end
      end
      D_TX: begin
        if (scl_fall) begin
          if (q.bitc == 4'h7) begin
            d.sda_oe = 1'b0;
            d.st = D_TX_ACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6]; // msb first [RULE_03]
            d.bitc = q.bitc + 1'b1;
          end
        end
      end
      D_TX_ACK: begin
        if (scl_rise) begin
          d.mnack = q.sda_s[2];
        end else if (scl_fall) begin
          if (q.mnack) begin
            d.st = D_IDLE; // controller ended the read [RULE_05] [RULE_08]
          end else begin
            d.bidx = (q.bidx == 3'h7) ? q.bidx : q.bidx + 1'b1;
            nb = tx_byte(q, d.bidx); // saturates, so long reads stay on fill bytes
            d.sh = nb;
            d.sda_oe = ~nb[7]; // keep supplying bytes [RULE_05]
            d.bitc = 4'h0;
            d.st = D_TX;
          end
        end
      end
      default: begin
        d.sda_oe = 1'b0;
      end
    endcase

    // stop: carry out a three-byte write command
    if (bus_stop) begin
      d.st = D_IDLE;
      d.sda_oe = 1'b0;
      d.wr_act = 1'b0;
      if (q.wr_act && q.bidx == CMD_BYTES) begin
        if (q.cmd == CMD_PROG_ENTER && q.win && !q.prog) begin
          d.prog = 1'b1; // [RULE_12]
          d.measuring = 1'b0; // ends a measurement still running from the entry address
          d.nv_busy = 1'b1;
          d.nvtmr = TMR_W'(NV_LOAD_CYC); // [RULE_13]
        end else if (q.cmd == CMD_PROG_EXIT) begin
          d.prog = 1'b0; // [RULE_14]
        end else if (q.prog) begin
          d.nv_busy = 1'b1;
          d.nvtmr = TMR_W'(NV_LOAD_CYC); // [RULE_20]
          if (q.cmd == REG_HRES_RD) begin
            d.nvrd = q.hres; // [RULE_15]
          end else if (q.cmd == REG_TRES_RD) begin
            d.nvrd = q.tres; // [RULE_15]
          end else if (q.cmd == REG_ID_HI) begin
            d.nvrd = ID_HI; // [RULE_16]
          end else if (q.cmd == REG_ID_LO) begin
            d.nvrd = ID_LO; // [RULE_16]
          end else if (q.cmd == REG_HRES_WR) begin
            d.hres = {q.b1, q.b2}; // [RULE_24] [RULE_18]
            d.nvtmr = TMR_W'(NV_STORE_CYC); // [RULE_20]
          end else if (q.cmd == REG_TRES_WR) begin
            d.tres = {q.b1, q.b2}; // [RULE_24] [RULE_18]
            d.nvtmr = TMR_W'(NV_STORE_CYC);
          end else begin
            d.nv_busy = 1'b0; // unknown register, nothing to do
          end
        end
      end
    end

    // start (also repeated start) restarts address reception
    if (bus_start) begin
      d.st = D_RX;
      d.is_addr = 1'b1;
      d.bitc = 4'h0;
      d.bidx = 3'h0;
      d.sda_oe = 1'b0;
      d.wr_act = 1'b0;
    end

    // end of cycle updates results; placed last so it beats a same-cycle fetch
    if (q.measuring) begin
      d.mtmr = q.mtmr - 1'b1;
      if (q.mtmr == TMR_W'(1)) begin
        d.measuring = 1'b0; // core back to sleep [RULE_02]
        d.hum = hum_in;
        d.tmp = tmp_in;
        d.stat = STAT_VALID; // [RULE_10]
      end
    end
  end

  // single state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign lnk.dev_sda_oe = q.sda_oe;
  assign core_awake = q.measuring;
  assign prog_mode = q.prog;
  assign nv_busy = q.nv_busy;
endmodule // ht_dev

//--- design/ht_host.sv
`timescale 1ns/100ps
// byte buffer between the link engine and the user
module ht_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign in_ready = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem[rp_q[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end

  // storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule // ht_fifo

// controller end: makes scl, runs one transfer per command
module ht_host (
  input wire logic sys_clk,
  input wire logic nrst,
  ht_link_if.host lnk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_len,
  input wire logic [23:0] cmd_wdata,
  output logic nack_seen,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  import ht_pkg::*;

  typedef struct packed {
    ht_hst_type st;
    logic [1:0] qtr;
    logic [5:0] div;
    logic [1:0] sda_s;
    logic scl_oe;
    logic sda_oe;
    logic rd;
    logic [2:0] len;
    logic [23:0] wdat;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic [2:0] bidx;
    logic nack;
    logic rdy;
  } ht_host_st_type;

  localparam ht_host_st_type RST = '{
    st: H_IDLE, qtr: 2'h0, div: 6'h00, sda_s: 2'h3, scl_oe: 1'b0, sda_oe: 1'b0,
    rd: 1'b0, len: 3'h0, wdat: 24'h000000, sh: 8'h00, bitc: 4'h0, bidx: 3'h0,
    nack: 1'b0, rdy: 1'b1};

  ht_host_st_type q;
  ht_host_st_type d;
  logic tick;
  logic rx_data;
  logic push;
  logic f_ready;

  // quarter-bit enable from the divider
  assign tick = q.div == 6'(SCL_QTR_CYC - 1);
  assign rx_data = q.rd && q.bidx != 3'h0;
  // read byte complete: hand it over at the ack bit
  assign push = tick && q.st == H_BIT && q.qtr == 2'h0 && q.bitc == 4'h8 && rx_data;

  ht_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data(q.sh),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // next state; a full buffer holds scl low until space frees
  always_comb begin
    d = q;
    d.sda_s = {q.sda_s[0], lnk.sda};
    d.div = tick ? 6'h00 : q.div + 1'b1;
    case (q.st)
      H_IDLE: begin
        d.rdy = 1'b1;
        if (cmd_valid) begin
          d.rdy = 1'b0;
          d.rd = cmd_read;
          d.len = cmd_len;
          d.wdat = cmd_wdata;
          d.nack = 1'b0;
          d.qtr = 2'h0;
          d.div = 6'h00;
          d.st = H_START;
        end
      end
      H_START: begin
        if (tick) begin
          d.qtr = q.qtr + 1'b1;
          if (q.qtr == 2'h0) begin
            d.sda_oe = 1'b1; // start: sda falls with scl high
          end else begin
            d.scl_oe = 1'b1;
            d.qtr = 2'h0;
            d.bitc = 4'h0;
            d.bidx = 3'h0;
            d.sh = {HT_ADDR, q.rd}; // [RULE_01] [RULE_04]
            d.st = H_BIT;
          end
        end
      end
      H_BIT: begin
        if (tick && !(push && !f_ready)) begin
          d.qtr = q.qtr + 1'b1;
          case (q.qtr)
            2'h0: begin
              if (q.bitc != 4'h8) begin
                d.sda_oe = rx_data ? 1'b0 : ~q.sh[7];
              end else begin
                d.sda_oe = rx_data && q.bidx != q.len; // nack on last [RULE_05]
              end
            end
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bitc != 4'h8) begin
                d.sh = {q.sh[6:0], q.sda_s[1]};
              end else if (!rx_data && q.sda_s[1]) begin
                d.nack = 1'b1;
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              d.bitc = q.bitc + 1'b1;
              if (q.bitc == 4'h8) begin
                d.bitc = 4'h0;
                if (q.nack || q.bidx == q.len) begin
                  d.st = H_STOP;
                end else begin
                  d.bidx = q.bidx + 1'b1;
                  d.sh = q.rd ? FILL_BYTE : q.wdat[23:16]; // msb first [RULE_24]
                  d.wdat = {q.wdat[15:0], ZERO_BYTE};
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          d.qtr = q.qtr + 1'b1;
          if (q.qtr == 2'h0) begin
            d.sda_oe = 1'b1;
          end else if (q.qtr == 2'h1) begin
            d.scl_oe = 1'b0;
          end else begin
            d.sda_oe = 1'b0; // stop: sda rises with scl high
            d.st = H_IDLE;
            d.rdy = 1'b1;
          end
        end
      end
    endcase
  end

  // single state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign lnk.host_scl_oe = q.scl_oe;
  assign lnk.host_sda_oe = q.sda_oe;
  assign cmd_ready = q.rdy;
  assign nack_seen = q.nack;
endmodule // ht_host

//--- verification/ht_link_props.sv
`timescale 1ns/100ps
// wire watcher between the two ends
module ht_link_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import ht_pkg::*;
  logic scl_q, sda_q, first_q, rd_q, hit_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rise, start, stop, match, wr_bit, rd_bit;
  // wire events straight off the wires, two clocks ahead of the device
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  assign match = sh_q[7:1] == HT_ADDR;
  assign wr_bit = rise & ~first_q & hit_q & ~rd_q;
  assign rd_bit = rise & ~first_q & rd_q;
  // byte tracker: bit 8 is the ack slot, first_q marks the address byte
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      hit_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        first_q <= 1'b1;
        bit_q <= 4'h0;
      end else if (rise && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        first_q <= 1'b0;
        if (first_q) begin
          rd_q <= sh_q[0];
          hit_q <= match;
        end
      end else if (rise) begin
        sh_q <= {sh_q[6:0], sda};
        bit_q <= bit_q + 4'h1;
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // eighth falling edge of our own address
  sequence addr_end_s;
    $fell(scl) && first_q && bit_q == 4'h8 && match;
  endsequence
  sequence dev_quiet_s;
    !dev_sda_oe [*4];
  endsequence
  dev_hold_a: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device moved sda while scl high");
  addr_quiet_a: assert property (rise && first_q && bit_q != 4'h8 |-> !dev_sda_oe)
    else $error("device drove sda in the address");
  addr_ack_a: assert property (rise && first_q && bit_q == 4'h8 |-> dev_sda_oe == match)
    else $error("address ack wrong");
  ack_soon_a: assert property (addr_end_s |-> ##[1:5] dev_sda_oe)
    else $error("address ack late");
  wr_quiet_a: assert property (wr_bit && bit_q != 4'h8 |-> !dev_sda_oe)
    else $error("device drove a write data bit");
  wr_ack_a: assert property (wr_bit && bit_q == 4'h8 |-> dev_sda_oe)
    else $error("write byte not acked");
  rd_free_a: assert property (rd_bit && bit_q == 4'h8 |-> !dev_sda_oe)
    else $error("device held the host ack slot");
  no_clash_a: assert property (rd_bit && dev_sda_oe |-> !host_sda_oe)
    else $error("both ends drive sda");
  miss_quiet_a: assert property (!first_q && !hit_q |-> !dev_sda_oe)
    else $error("device active when not addressed");
  stop_quiet_a: assert property (stop |=> dev_quiet_s)
    else $error("device drove sda after stop");
endmodule // ht_link_props

//--- verification/humidity_temp_i2c_command_logic_bench.sv
`timescale 1ns/100ps
// both ends on one link; the bench drives the user sides
module humidity_temp_i2c_command_logic_bench;
  import ht_pkg::*;
  // short conversions keep the run small
  localparam int M8 = 400;
  localparam int M10 = 500;
  localparam int M12 = 600;
  localparam int M14 = 800;
  localparam logic [15:0] ID_LO_V = 16'h9c3e; // arbitrary value
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [2:0] cmd_len = 3'h0;
  logic [23:0] cmd_wdata = 24'h0;
  logic rd_ready = 1'b0;
  logic [13:0] hum_in = 14'h0;
  logic [13:0] tmp_in = 14'h0;
  logic cmd_ready, nack_seen, rd_valid, core_awake, prog_mode, nv_busy;
  logic [7:0] rd_data;
  logic [31:0] rnd = 32'h00014657;
  logic [1:0] code;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int awake = 0;
  int low = 0;
  always #25 sys_clk = ~sys_clk;
  ht_link_if ht_link_if_i ();
  ht_dev #(.MEAS_8_CYC(M8), .MEAS_10_CYC(M10), .MEAS_12_CYC(M12), .MEAS_14_CYC(M14),
    .NV_STORE_CYC(300), .PROG_WIN_CYC(30000), .ID_LO(ID_LO_V)) ht_dev_i (.sys_clk(sys_clk),
    .nrst(nrst), .lnk(ht_link_if_i.dev), .hum_in(hum_in), .tmp_in(tmp_in),
    .core_awake(core_awake), .prog_mode(prog_mode), .nv_busy(nv_busy));
  ht_host ht_host_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(ht_link_if_i.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_len(cmd_len),
    .cmd_wdata(cmd_wdata), .nack_seen(nack_seen), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  ht_link_props ht_link_props_i (.sys_clk(sys_clk), .nrst(nrst),
    .host_scl_oe(ht_link_if_i.host_scl_oe), .host_sda_oe(ht_link_if_i.host_sda_oe),
    .dev_sda_oe(ht_link_if_i.dev_sda_oe), .scl(ht_link_if_i.scl), .sda(ht_link_if_i.sda));
  // awake-time counter and run ceiling
  always @(negedge sys_clk) begin
    cyc++;
    if (core_awake === 1'b1) awake++;
    if (cyc == 100000) begin
      num_errors++;
      test_done();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int meas(input logic [1:0] c);
    return c == 2'h0 ? M8 : c == 2'h1 ? M10 : c == 2'h2 ? M12 : M14;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one command; cmd_ready is high when idle, so the next rising edge takes it
  task automatic xfer(input logic rd, input logic [2:0] len, input logic [23:0] wd,
    input bit wt);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_len = len;
    cmd_wdata = wd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (int i = 0; i < 40000 && wt && cmd_ready !== 1'b1; i++) @(negedge sys_clk);
    if (wt && cmd_ready !== 1'b1) num_errors++;
    // the device sees the stop a few cycles after the host ends it
    if (wt) repeat (4) @(negedge sys_clk);
  endtask
  // queue n expected bytes, msb first; past byte four the device sends ff
  task automatic exp_bytes(input int n, input logic [31:0] v, input logic [31:0] m);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(i < 4 ? {m[31:24], v[31:24]} : 16'hffff);
      v = v << 8;
      m = m << 8;
    end
  endtask
  // drain in order with random stalls on rd_ready
  task automatic drain();
    logic [15:0] e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      for (int i = 0; i < 20000 && rd_valid !== 1'b1; i++) @(negedge sys_clk);
      if (rd_valid !== 1'b1) num_errors++;
      rnd = lfsr(rnd);
      repeat (rnd[1:0]) @(negedge sys_clk);
      check("read byte", {8'h0, rd_data & e[15:8]}, {8'h0, e[7:0]});
      rd_ready = 1'b1;
      @(negedge sys_clk);
      rd_ready = 1'b0;
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    // fetch before any result: stale code, data meaningless
    xfer(1'b1, 3'h4, 24'h0, 1'b1);
    exp_bytes(4, 32'h40000000, 32'hc0000000);
    $display("test early fetch done");
    xfer(1'b0, 3'h3, {CMD_PROG_ENTER, ZERO_BYTE, ZERO_BYTE}, 1'b1);
    check("entry nack", 16'(nack_seen), 16'h0);
    check("entry busy", 16'(nv_busy), 16'h1);
    for (int i = 0; i < 5000 && nv_busy !== 1'b0; i++) @(negedge sys_clk);
    check("prog mode", 16'(prog_mode), 16'h1);
    // random humidity code; other bits keep their reset zeros
    rnd = lfsr(rnd);
    code = rnd[1:0];
    xfer(1'b0, 3'h3, {REG_HRES_WR, 4'h0, code, 10'h0}, 1'b1);
    for (int i = 0; i < 5000 && nv_busy !== 1'b0; i++) @(negedge sys_clk);
    xfer(1'b0, 3'h3, {REG_HRES_RD, ZERO_BYTE, ZERO_BYTE}, 1'b1);
    for (int i = 0; i < 5000 && nv_busy !== 1'b0; i++) @(negedge sys_clk);
    xfer(1'b1, 3'h2, 24'h0, 1'b1);
    exp_bytes(2, {4'h0, code, 26'h0}, 32'hffff0000);
    xfer(1'b0, 3'h3, {REG_ID_LO, ZERO_BYTE, ZERO_BYTE}, 1'b1);
    for (int i = 0; i < 5000 && nv_busy !== 1'b0; i++) @(negedge sys_clk);
    xfer(1'b1, 3'h2, 24'h0, 1'b1);
    exp_bytes(2, {ID_LO_V, 16'h0}, 32'hffff0000);
    xfer(1'b0, 3'h3, {CMD_PROG_EXIT, ZERO_BYTE, ZERO_BYTE}, 1'b1);
    check("prog exit", 16'(prog_mode), 16'h0);
    $display("test programming done");
    // one measurement; mixed resolutions take the mean time
    for (int i = 0; i < 5000 && core_awake !== 1'b0; i++) @(negedge sys_clk);
    rnd = lfsr(rnd);
    hum_in = rnd[13:0];
    tmp_in = rnd[29:16];
    awake = 0;
    xfer(1'b0, 3'h0, 24'h0, 1'b1);
    for (int i = 0; i < 5000 && core_awake !== 1'b0; i++) @(negedge sys_clk);
    low = awake - (meas(code) + M14) / 2;
    check("awake time", 16'(low >= -1 && low <= 1), 16'h1);
    xfer(1'b1, 3'h4, 24'h0, 1'b1);
    exp_bytes(4, {STAT_VALID, hum_in, tmp_in, 2'b00}, 32'hfffffffc);
    $display("test measurement done");
    // more bytes than the 16 entries: the host must hold scl low
    xfer(1'b1, 3'h7, 24'h0, 1'b0);
    exp_bytes(7, {STAT_STALE, hum_in, tmp_in, 2'b00}, 32'hfffffffc);
    low = 0;
    for (int i = 0; i < 30000 && low < 1000; i++) begin
      @(negedge sys_clk);
      low = ht_link_if_i.scl === 1'b0 ? low + 1 : 0;
    end
    check("scl stall", 16'(low >= 1000), 16'h1);
    drain();
    for (int i = 0; i < 20000 && cmd_ready !== 1'b1; i++) @(negedge sys_clk);
    check("ready", 16'(cmd_ready), 16'h1);
    $display("test buffer done");
    test_done();
  end
endmodule // humidity_temp_i2c_command_logic_bench
